// ==== event_counter.sv ====
// Consecutive switching-cycle event counter for one fault kind
module event_counter (
    input wire logic ref_clk, // System clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic clk_en, // Freezes state while low
    fault_link_if.counter lnk // Event link
);
    // --------------------------------------------------
    // State
    // --------------------------------------------------
    logic [3:0] run_r, run_nxt; // Consecutive cycles with an event
    logic seen_r, seen_nxt; // Event latched in current cycle
    logic fault_r, fault_nxt; // Fault pulse
    logic [3:0] need; // Events required: 2n+1
    assign need = {lnk.count_code, 1'b1};
    assign lnk.fault = fault_r;
    // Next-state: at most one event per cycle, judged at cycle end
    always_comb begin
        run_nxt = run_r;
        seen_nxt = seen_r | lnk.event_hit;
        fault_nxt = 1'b0;
        if (lnk.cycle_start) begin
            // An event on the boundary edge counts for the new cycle
            seen_nxt = lnk.event_hit;
            if (!seen_r) begin
                run_nxt = 4'h0;
            end else if (run_r + 4'h1 >= need) begin
                run_nxt = 4'h0;
                fault_nxt = 1'b1;
            end else begin
                run_nxt = run_r + 4'h1;
            end
        end
    end
    // Registers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            run_r <= 4'h0;
            seen_r <= 1'b0;
            fault_r <= 1'b0;
        end else if (clk_en) begin
            run_r <= run_nxt;
            seen_r <= seen_nxt;
            fault_r <= fault_nxt;
        end
    end
endmodule

// ==== fault_link_if.sv ====
// Event and fault signals between the top and the fault counter
interface fault_link_if;
    logic cycle_start; // Start of each switching cycle
    logic event_hit; // Event seen this cycle
    logic [2:0] count_code; // Fault count field
    logic fault; // Threshold reached, one-cycle pulse
    modport owner (output cycle_start, output event_hit, output count_code, input fault);
    modport counter (input cycle_start, input event_hit, input count_code, output fault);
endinterface

// ==== pcs_assertions.sv ====
// Port-level concurrent checks for the current-sense configuration block
module pcs_assertions (
    input logic ref_clk, // Clock
    input logic rst_n, // Sync reset, active low
    input logic clk_en, // Run enable
    input logic cmd_wr, // Write strobe
    input logic [7:0] cmd_code, // Command code
    input logic [15:0] cmd_wdata, // Write word
    input logic cmd_ack, // Accept pulse
    input logic cmd_nack, // Refuse pulse
    input logic ramp_active, // Ramp in progress
    input logic [15:0] vout_target_mv, // Clamped target
    input logic pwm_high_req, // High-side request
    input logic drive_high, // Gated high-side drive
    input logic pg_level, // Power good state
    input logic power_good_output_o, // Pin value
    input logic power_good_output_oe_n, // Pin enable, low drives
    input logic [15:0] int_temp, // Internal reading
    input logic [15:0] ext_temp, // External reading
    input logic [15:0] fault_temp, // Fault temperature
    input logic temp_comp_ext, // Compensation source
    input logic [6:0] min_on_ticks, // Minimum on-time
    input logic over_current_fault // Fault pulse
);
    // ------
    // Shadows of written settings
    // ------
    logic [15:0] vmin_r, vmin_nxt, misc_r, misc_nxt; // Shadow copies
    logic wr_ok; // Write taken at this edge
    assign wr_ok = clk_en && cmd_wr;
    // Follow writes so checks can compare against the live setting
    always_comb begin
        vmin_nxt = (wr_ok && cmd_code == 8'hce) ? cmd_wdata : vmin_r;
        misc_nxt = (wr_ok && cmd_code == 8'hd1) ? cmd_wdata : misc_r;
    end
    always_ff @(posedge ref_clk) begin
        vmin_r <= rst_n ? vmin_nxt : 16'h0000;
        misc_r <= rst_n ? misc_nxt : 16'h0000;
    end
    default clocking @(posedge ref_clk); endclocking
    default disable iff (!rst_n);
    sequence s_known_wr;
        wr_ok && (cmd_code inside {8'hce, 8'hd0, 8'hd1});
    endsequence
    sequence s_odd_wr;
        wr_ok && !(cmd_code inside {8'hce, 8'hd0, 8'hd1});
    endsequence
    // Previous edge was running, so $past values are real
    sequence s_settled;
        $past(rst_n) && $past(clk_en);
    endsequence
    a_wr_acked: assert property (s_known_wr |=> cmd_ack && !cmd_nack)
        else $error("known write not acknowledged");
    a_odd_refused: assert property (s_odd_wr |=> cmd_nack && !cmd_ack)
        else $error("unknown write not refused");
    a_ramp_floor: assert property (s_settled ##0 $past(ramp_active) |-> vout_target_mv >= $past(vmin_r))
        else $error("ramp target under minimum");
    a_drive_gate: assert property (s_settled |-> drive_high == ($past(pwm_high_req) && $past(misc_r[10])))
        else $error("drive gate wrong");
    a_pg_push: assert property (s_settled ##0 $past(misc_r[2])
        |-> !power_good_output_oe_n && power_good_output_o == $past(pg_level))
        else $error("push-pull power good wrong");
    a_pg_drain: assert property (s_settled ##0 !$past(misc_r[2])
        |-> !power_good_output_o && power_good_output_oe_n == $past(pg_level))
        else $error("open-drain power good wrong");
    a_temp_src: assert property (s_settled |-> fault_temp == ($past(misc_r[0]) ? $past(ext_temp) : $past(int_temp)))
        else $error("fault temperature source wrong");
    a_comp_src: assert property (temp_comp_ext == misc_r[1])
        else $error("compensation source wrong");
    a_min_on: assert property (min_on_ticks == (misc_r[7] ? {1'b0, misc_r[15:11], 1'b0} + 7'h02 : 7'h00))
        else $error("minimum on-time wrong");
    a_fault_pulse: assert property ($rose(over_current_fault) |=> !over_current_fault)
        else $error("fault pulse too long");
endmodule
bind pwm_current_sense_config pcs_assertions chk (.*);

// ==== pstage_model.sv ====
// Power stage model: switching cycle pins and current comparators
module pstage_model #(
    parameter int PERIOD = 40 // Clocks per switching cycle
) (
    input logic ref_clk, // Clock
    input logic run, // Switch while high
    input logic oc_req, // Over-current comparator level
    input logic uc_req, // Under-current comparator level
    output logic cycle_start, // Cycle start pin
    output logic switch_edge, // Transition pin
    output logic high_side_on, // High side conducting
    output logic over_current_event, // Comparator pin
    output logic under_current_event // Comparator pin
);
    int ph = 0; // Phase within the cycle
    initial {cycle_start, switch_edge, high_side_on, over_current_event, under_current_event} = 5'h00;
    // Pins move on the falling edge; both transitions give an edge pulse
    always @(negedge ref_clk) begin
        ph <= run ? (ph + 1) % PERIOD : 0;
        cycle_start <= run && ph < 4;
        high_side_on <= run && ph < PERIOD / 2;
        switch_edge <= run && (ph % (PERIOD / 2)) < 4;
        over_current_event <= oc_req;
        under_current_event <= uc_req;
    end
endmodule

// ==== pwm_current_sense_config.sv ====
// Configuration, blanking and current-fault supervision of a point-of-load controller
`include "pwm_sense_defs.svh"
module pwm_current_sense_config (
    input wire logic ref_clk, // 100 MHz clock
    input wire logic rst_n, // Synchronous reset, active low
    input wire logic clk_en, // Freezes all state while low
    input wire logic cmd_wr, // Word write strobe
    input wire logic cmd_rd, // Word read strobe
    input wire logic [7:0] cmd_code, // Command code
    input wire logic [15:0] cmd_wdata, // Write word
    output logic [15:0] cmd_rdata, // Read word, registered
    output logic cmd_ack, // Command accepted, registered pulse
    output logic cmd_nack, // Unknown command, registered pulse
    input wire logic ramp_active, // Start-up or shut-down ramp in progress
    input wire logic [15:0] ramp_target_mv, // Raw ramp target
    output logic [15:0] vout_target_mv, // Clamped target, registered
    input wire logic switch_edge, // Pin: switch transition
    input wire logic high_side_on, // Pin: high-side conducting
    input wire logic cycle_start, // Pin: start of switching cycle
    input wire logic over_current_event, // Pin: over-current comparator
    input wire logic under_current_event, // Pin: under-current comparator
    output logic sample_strobe, // Take current sample, registered pulse
    output logic [1:0] sense_range, // Sense converter range, registered
    output logic over_current_fault, // Registered one-cycle pulse
    output logic under_current_fault, // Registered one-cycle pulse
    output logic [6:0] min_on_ticks, // Minimum on-time in 1/512 period units
    output logic min_duty_en, // Minimum duty limit active
    input wire logic pwm_high_req, // High-side request from modulator
    input wire logic pwm_low_req, // Low-side request from modulator
    output logic drive_high, // Gated high-side drive, registered
    output logic drive_low, // Gated low-side drive, registered
    input wire logic pg_level, // Power good state
    output logic power_good_output_o, // Power good pin output value
    output logic power_good_output_oe_n, // Power good enable, low drives
    input wire logic [15:0] int_temp, // Internal sensor reading
    input wire logic [15:0] ext_temp, // External sensor reading
    output logic [15:0] fault_temp, // Temperature for fault checks, registered
    output logic temp_comp_ext // Use external reading for current compensation
);
    // --------------------------------------------------
    // Pin synchronisers
    // --------------------------------------------------
    logic [4:0] sync1_r, sync2_r, sync_prev_r; // Two stages plus edge history
    logic [4:0] pins;
    logic sw_e, hs_on, cyc_e, oc_lvl, uc_lvl;
    assign pins = {switch_edge, high_side_on, cycle_start, over_current_event, under_current_event};
    assign sw_e = sync2_r[4] & ~sync_prev_r[4]; // Rising edge only
    assign hs_on = sync2_r[3];
    assign cyc_e = sync2_r[2] & ~sync_prev_r[2];
    assign oc_lvl = sync2_r[1];
    assign uc_lvl = sync2_r[0];
    // Synchroniser stages; first stage feeds only the second
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            sync1_r <= 5'h00;
            sync2_r <= 5'h00;
            sync_prev_r <= 5'h00;
        end else if (clk_en) begin
            sync1_r <= pins;
            sync2_r <= sync1_r;
            sync_prev_r <= sync2_r;
        end
    end
    // --------------------------------------------------
    // Register file
    // --------------------------------------------------
    logic [15:0] min_regulation_voltage_r, min_regulation_voltage_nxt; // RW
    logic [15:0] current_sense_setup_r, current_sense_setup_nxt; // RW
    logic [15:0] misc_device_setup_r, misc_device_setup_nxt; // RW
    logic [15:0] rdata_nxt;
    logic ack_nxt, nack_nxt;
    logic [4:0] wblank;
    logic [1:0] wmeth, wrange;
    assign wblank = cmd_wdata[`BLANK_HI:`BLANK_LO];
    assign wmeth = cmd_wdata[`METH_HI:`METH_LO];
    assign wrange = cmd_wdata[`RANGE_HI:`RANGE_LO];
    // Command decode; reserved fields are replaced so the logic never runs on them
    always_comb begin
        min_regulation_voltage_nxt = min_regulation_voltage_r;
        current_sense_setup_nxt = current_sense_setup_r;
        misc_device_setup_nxt = misc_device_setup_r;
        rdata_nxt = cmd_rdata;
        ack_nxt = 1'b0;
        nack_nxt = 1'b0;
        if (cmd_wr || cmd_rd) begin
            if (cmd_code == `CMD_MIN_REG_VOLT) begin
                ack_nxt = 1'b1;
                rdata_nxt = min_regulation_voltage_r;
                if (cmd_wr) begin
                    min_regulation_voltage_nxt = cmd_wdata;
                end
            end else if (cmd_code == `CMD_SENSE_SETUP) begin
                ack_nxt = 1'b1;
                rdata_nxt = current_sense_setup_r;
                if (cmd_wr) begin
                    current_sense_setup_nxt = cmd_wdata;
                    // Over-range blanking clamps to the longest defined delay
                    if (wblank > `BLANK_MAX_CODE) begin
                        current_sense_setup_nxt[`BLANK_HI:`BLANK_LO] = `BLANK_MAX_CODE;
                    end
                    // Undefined method keeps the previous choice
                    if (wmeth == 2'b11) begin
                        current_sense_setup_nxt[`METH_HI:`METH_LO] =
                            current_sense_setup_r[`METH_HI:`METH_LO];
                    end
                    // Undefined range falls back to the widest, which cannot clip
                    if (wrange == 2'b11) begin
                        current_sense_setup_nxt[`RANGE_HI:`RANGE_LO] = 2'b10;
                    end
                end
            end else if (cmd_code == `CMD_MISC_SETUP) begin
                ack_nxt = 1'b1;
                rdata_nxt = misc_device_setup_r;
                if (cmd_wr) begin
                    misc_device_setup_nxt = cmd_wdata;
                end
            end else begin
                nack_nxt = 1'b1; // Unmapped command
                rdata_nxt = 16'h0000;
            end
        end
    end
    // Register file state
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            min_regulation_voltage_r <= `RST_MIN_REG_VOLT;
            current_sense_setup_r <= `RST_SENSE_SETUP;
            misc_device_setup_r <= `RST_MISC_SETUP;
            cmd_rdata <= 16'h0000;
            cmd_ack <= 1'b0;
            cmd_nack <= 1'b0;
        end else if (clk_en) begin
            min_regulation_voltage_r <= min_regulation_voltage_nxt;
            current_sense_setup_r <= current_sense_setup_nxt;
            misc_device_setup_r <= misc_device_setup_nxt;
            cmd_rdata <= rdata_nxt;
            cmd_ack <= ack_nxt;
            cmd_nack <= nack_nxt;
        end
    end
    // --------------------------------------------------
    // Blanking and sampling sequencer
    // --------------------------------------------------
    pwm_sense_pkg::meas_state_t st_r, st_nxt; // Sequencer state
    pwm_sense_pkg::sense_method_t meth;
    logic [8:0] blank_cnt_r, blank_cnt_nxt; // Remaining blanking cycles
    logic [8:0] blank_cycles; // Code times step cycles
    logic slope_ok; // Transition matches selected slope
    logic samp_nxt;
    assign meth = pwm_sense_pkg::sense_method_t'(current_sense_setup_r[`METH_HI:`METH_LO]);
    // 32 ns rounds up to 4 cycles, so the wait is never short of the delay
    assign blank_cycles = 9'(current_sense_setup_r[`BLANK_HI:`BLANK_LO] * `BLANK_STEP_CYC);
    // Falling slope follows high-side turn-off, rising follows turn-on
    always_comb begin
        slope_ok = 1'b0;
        case (meth)
            pwm_sense_pkg::meth_down_t_v: slope_ok = ~hs_on;
            pwm_sense_pkg::meth_up_t_v: slope_ok = hs_on;
            default: slope_ok = 1'b0;
        endcase
    end
    // Sequencer next state; transitions during blanking are ignored, it runs to the end
    always_comb begin
        st_nxt = st_r;
        blank_cnt_nxt = blank_cnt_r;
        samp_nxt = 1'b0;
        case (st_r)
            pwm_sense_pkg::st_idle: begin
                if (sw_e && slope_ok) begin
                    if (blank_cycles == 9'h000) begin
                        st_nxt = pwm_sense_pkg::st_measure;
                    end else begin
                        blank_cnt_nxt = blank_cycles;
                        st_nxt = pwm_sense_pkg::st_blank;
                    end
                end
            end
            pwm_sense_pkg::st_blank: begin
                if (blank_cnt_r <= 9'h001) begin
                    st_nxt = pwm_sense_pkg::st_measure;
                end
                blank_cnt_nxt = blank_cnt_r - 9'h001;
            end
            pwm_sense_pkg::st_measure: begin
                samp_nxt = 1'b1;
                st_nxt = pwm_sense_pkg::st_idle;
            end
            default: st_nxt = pwm_sense_pkg::st_idle;
        endcase
    end
    // Sequencer registers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            st_r <= pwm_sense_pkg::st_idle;
            blank_cnt_r <= 9'h000;
            sample_strobe <= 1'b0;
        end else if (clk_en) begin
            st_r <= st_nxt;
            blank_cnt_r <= blank_cnt_nxt;
            sample_strobe <= samp_nxt;
        end
    end
    // --------------------------------------------------
    // Consecutive-event fault counters
    // --------------------------------------------------
    fault_link_if oc_lnk ();
    fault_link_if uc_lnk ();
    // Events count only on a sample, keeping them tied to measurement
    assign oc_lnk.cycle_start = cyc_e;
    assign oc_lnk.event_hit = oc_lvl & sample_strobe;
    assign oc_lnk.count_code = current_sense_setup_r[`FCNT_HI:`FCNT_LO];
    assign uc_lnk.cycle_start = cyc_e;
    assign uc_lnk.event_hit = uc_lvl & sample_strobe;
    assign uc_lnk.count_code = current_sense_setup_r[`FCNT_HI:`FCNT_LO];
    assign over_current_fault = oc_lnk.fault;
    assign under_current_fault = uc_lnk.fault;
    event_counter oc_cnt (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .lnk(oc_lnk));
    event_counter uc_cnt (.ref_clk(ref_clk), .rst_n(rst_n), .clk_en(clk_en), .lnk(uc_lnk));
    // --------------------------------------------------
    // Outputs steered by configuration
    // --------------------------------------------------
    logic [15:0] vtgt_nxt;
    logic pg_o_nxt, pg_oe_n_nxt;
    assign sense_range = current_sense_setup_r[`RANGE_HI:`RANGE_LO];
    assign min_duty_en = misc_device_setup_r[`BIT_MIND_EN];
    // Ticks of 1/512 period, up to 64 so seven bits are needed; zero when the limit is off
    assign min_on_ticks = min_duty_en ?
        {6'({1'b0, misc_device_setup_r[`MIND_HI:`MIND_LO]} + 6'h01), 1'b0} : 7'h00;
    assign temp_comp_ext = misc_device_setup_r[`BIT_EXT_TEMP_EN];
    // Ramp clamp and power-good pin drive
    always_comb begin
        vtgt_nxt = ramp_target_mv;
        if (ramp_active && ramp_target_mv < min_regulation_voltage_r) begin
            vtgt_nxt = min_regulation_voltage_r;
        end
        if (misc_device_setup_r[`BIT_PG_PUSH]) begin
            pg_o_nxt = pg_level;
            pg_oe_n_nxt = 1'b0;
        end else begin
            pg_o_nxt = 1'b0;
            pg_oe_n_nxt = pg_level; // Released when good
        end
    end
    // Output registers
    always_ff @(posedge ref_clk) begin
        if (!rst_n) begin
            vout_target_mv <= 16'h0000;
            drive_high <= 1'b0;
            drive_low <= 1'b0;
            power_good_output_o <= 1'b0;
            power_good_output_oe_n <= 1'b0;
            fault_temp <= 16'h0000;
        end else if (clk_en) begin
            vout_target_mv <= vtgt_nxt;
            drive_high <= pwm_high_req & misc_device_setup_r[`BIT_DRIVE_EN];
            drive_low <= pwm_low_req & misc_device_setup_r[`BIT_DRIVE_EN];
            power_good_output_o <= pg_o_nxt;
            power_good_output_oe_n <= pg_oe_n_nxt;
            fault_temp <= misc_device_setup_r[`BIT_EXT_TEMP_FAULT] ? ext_temp : int_temp;
        end
    end
endmodule

// ==== pwm_current_sense_config_tb_top.sv ====
// Self-checking bench for the current-sense configuration block
`define check_eq(nm, e, a) begin num_checks++; if ((a) !== (e)) begin num_errors++; \
    $display("ERROR %s expected %h seen %h", nm, e, a); end end
module pwm_current_sense_config_tb_top;
    timeunit 1ns;
    timeprecision 1ps;
    logic ref_clk = 0, rst_n = 0, clk_en = 1, cmd_wr = 0, cmd_rd = 0, ramp_active = 0;
    logic [7:0] cmd_code = 8'h00;
    logic [15:0] cmd_wdata = 16'h0000, ramp_target_mv = 16'h0000, cmd_rdata, vout_target_mv, fault_temp;
    logic pwm_high_req = 0, pwm_low_req = 0, pg_level = 0, run = 0, oc_req = 0, uc_req = 0;
    logic [15:0] int_temp = 16'h0123, ext_temp = 16'h0456;
    logic cmd_ack, cmd_nack, sample_strobe, over_current_fault, under_current_fault, min_duty_en;
    logic drive_high, drive_low, power_good_output_o, power_good_output_oe_n, temp_comp_ext;
    logic cycle_start, switch_edge, high_side_on, over_current_event, under_current_event;
    logic [1:0] sense_range;
    logic [6:0] min_on_ticks;
    logic [15:0] misc_cases [4] = '{16'hfc87, 16'h0000, 16'h0080, 16'h0403}; // Settings for the misc scenario
    int num_errors = 0, num_checks = 0;
    pwm_current_sense_config dut (.*);
    pstage_model pst (.*);
    initial forever #5 ref_clk = ~ref_clk;
    // ------
    // Shared tasks
    // ------
    task automatic stop_test();
        $display("checks %0d errors %0d", num_checks, num_errors);
        if (num_errors == 0 && num_checks > 0) begin
            $display("TB: PASS");
        end else begin
            $display("TB: FAIL");
        end
        $finish;
    endtask
    // One command; strobe held for exactly one sampling edge
    task automatic cmd(input logic w, input logic [7:0] c, input logic [15:0] d,
                       output logic [1:0] an, output logic [15:0] r);
        // Start on a falling edge so the strobe always meets a full rising edge
        @(negedge ref_clk);
        cmd_wr = w;
        cmd_rd = !w;
        cmd_code = c;
        cmd_wdata = d;
        @(negedge ref_clk);
        cmd_wr = 1'b0;
        cmd_rd = 1'b0;
        an = {cmd_nack, cmd_ack};
        r = cmd_rdata;
    endtask
    task automatic wr(input logic [7:0] c, input logic [15:0] d);
        logic [1:0] an;
        logic [15:0] r;
        cmd(1'b1, c, d, an, r);
        `check_eq("write answer", 2'b01, an)
    endtask
    task automatic rd_chk(input logic [7:0] c, input logic [15:0] e);
        logic [1:0] an;
        logic [15:0] r;
        cmd(1'b0, c, 16'h0000, an, r);
        `check_eq("read answer", 2'b01, an)
        `check_eq("read word", e, r)
    endtask
    // ------
    // Scenarios
    // ------
    task automatic t_regs();
        logic [1:0] an;
        logic [15:0] r;
        rd_chk(8'hce, 16'h0000);
        rd_chk(8'hd0, 16'h0001);
        rd_chk(8'hd1, 16'h0000);
        cmd(1'b1, 8'hcf, 16'hffff, an, r);
        `check_eq("unknown answer", 2'b10, an)
        `check_eq("unknown word", 16'h0000, r)
        wr(8'hce, 16'hfedc);
        rd_chk(8'hce, 16'hfedc);
        // Oversized blanking clamps, method 11 keeps old, range 11 becomes 10
        wr(8'hd0, 16'hfb0f);
        rd_chk(8'hd0, 16'hd302);
        `check_eq("sense range", 2'b10, sense_range)
    endtask
    task automatic t_ramp();
        wr(8'hce, 16'h0400);
        ramp_active = 1'b1;
        ramp_target_mv = 16'h0100;
        @(negedge ref_clk);
        `check_eq("ramp clamp", 16'h0400, vout_target_mv)
        ramp_target_mv = 16'h0800;
        @(negedge ref_clk);
        `check_eq("ramp pass", 16'h0800, vout_target_mv)
        ramp_active = 1'b0;
        ramp_target_mv = 16'h0100;
        @(negedge ref_clk);
        `check_eq("no ramp", 16'h0100, vout_target_mv)
        clk_en = 1'b0;
        ramp_target_mv = 16'h0200;
        @(negedge ref_clk);
        `check_eq("frozen target", 16'h0100, vout_target_mv)
        clk_en = 1'b1;
    endtask
    task automatic t_misc(input logic [15:0] m);
        logic [6:0] on;
        wr(8'hd1, m);
        on = m[7] ? 7'(2 * (m[15:11] + 1)) : 7'h00;
        for (int g = 0; g < 2; g++) begin
            pg_level = g[0];
            pwm_high_req = g[0];
            pwm_low_req = !g[0];
            @(negedge ref_clk);
            `check_eq("drive high", g[0] & m[10], drive_high)
            `check_eq("drive low", !g[0] & m[10], drive_low)
            `check_eq("min duty on", m[7], min_duty_en)
            `check_eq("min on time", on, min_on_ticks)
            `check_eq("pg pin", m[2] ? {g[0], 1'b0} : {1'b0, g[0]}, {power_good_output_o, power_good_output_oe_n})
            `check_eq("comp source", m[1], temp_comp_ext)
            `check_eq("fault temp", m[0] ? ext_temp : int_temp, fault_temp)
        end
    endtask
    // Stop switching so no blanking is pending, then time one matching edge
    task automatic t_blank(input logic [1:0] m, input logic [4:0] c);
        int n;
        run = 1'b0;
        wr(8'hd0, {c, 3'b000, 4'h0, m, 2'b01});
        repeat (120) @(negedge ref_clk);
        run = 1'b1;
        n = 0;
        if (m == 2'b01) begin
            @(negedge high_side_on);
        end else begin
            @(posedge cycle_start);
        end
        while (!sample_strobe && n < 130) begin
            @(posedge ref_clk);
            #1;
            n++;
        end
        `check_eq("blank window", 1'b1, n >= 3 + 4 * c && n <= 6 + 4 * c)
    endtask
    task automatic t_no_method();
        int n;
        n = 0;
        wr(8'hd0, 16'h0001);
        repeat (200) begin
            @(posedge ref_clk);
            #1;
            n += sample_strobe;
        end
        `check_eq("no sampling", 0, n)
    endtask
    // Comparator level per switching cycle from p; count cycle starts to the fault
    task automatic t_fault(input logic [2:0] c, input logic [15:0] p, input logic uc, input int e);
        int k;
        logic prev, hit, wrong;
        wr(8'hd0, {5'h00, c, 4'h0, 2'b10, 2'b01});
        run = 1'b1;
        // One quiet cycle first clears any run left by the previous scenario
        repeat (2) @(posedge cycle_start);
        {k, prev, hit, wrong} = {32'h0000_0000, 3'b100};
        {uc_req, oc_req} = uc ? {p[0], 1'b0} : {1'b0, p[0]};
        for (int t = 0; t < 1000 && !hit; t++) begin
            @(posedge ref_clk);
            #1;
            hit = uc ? under_current_fault : over_current_fault;
            wrong |= uc ? over_current_fault : under_current_fault;
            if (cycle_start && !prev) begin
                k++;
                {uc_req, oc_req} = uc ? {k < 16 && p[k], 1'b0} : {1'b0, k < 16 && p[k]};
            end
            prev = cycle_start;
        end
        {uc_req, oc_req} = 2'b00;
        `check_eq("fault cycles", e, k)
        `check_eq("fault seen", 1'b1, hit)
        `check_eq("other fault", 1'b0, wrong)
    endtask
    initial begin
        repeat (4) @(negedge ref_clk);
        rst_n = 1'b1;
        t_regs();
        $display("register test done");
        t_ramp();
        $display("ramp test done");
        foreach (misc_cases[i]) t_misc(misc_cases[i]);
        $display("misc test done");
        t_blank(2'b10, 5'h00);
        t_blank(2'b01, 5'h03);
        t_blank(2'b10, 5'h1a);
        t_no_method();
        $display("blanking test done");
        t_fault(3'b010, 16'hffff, 1'b0, 5);
        t_fault(3'b001, 16'h003b, 1'b0, 6);
        t_fault(3'b000, 16'h0001, 1'b1, 1);
        t_fault(3'b111, 16'hffff, 1'b0, 15);
        $display("fault test done");
        stop_test();
    end
    initial begin
        #200us;
        num_errors++;
        $display("ERROR watchdog expired");
        stop_test();
    end
endmodule

// ==== pwm_sense_defs.svh ====
// Register offsets, field positions, reset values and timing counts
`ifndef PWM_SENSE_DEFS_SVH
`define PWM_SENSE_DEFS_SVH
// --------------------------------------------------
// Command codes
// --------------------------------------------------
`define CMD_MIN_REG_VOLT 8'hce
`define CMD_SENSE_SETUP 8'hd0
`define CMD_MISC_SETUP 8'hd1
// --------------------------------------------------
// Field positions
// --------------------------------------------------
`define BLANK_HI 15
`define BLANK_LO 11
`define FCNT_HI 10
`define FCNT_LO 8
`define METH_HI 3
`define METH_LO 2
`define RANGE_HI 1
`define RANGE_LO 0
`define MIND_HI 15
`define MIND_LO 11
`define BIT_DRIVE_EN 10
`define BIT_MIND_EN 7
`define BIT_PG_PUSH 2
`define BIT_EXT_TEMP_EN 1
`define BIT_EXT_TEMP_FAULT 0
// --------------------------------------------------
// Reset values and limits
// --------------------------------------------------
`define RST_MIN_REG_VOLT 16'h0000
`define RST_SENSE_SETUP 16'h0001
`define RST_MISC_SETUP 16'h0000
`define BLANK_MAX_CODE 5'h1a
`define BLANK_STEP_NS 32
`define CLK_PERIOD_NS 10
// Cycles per blanking step, rounded up as a least time
`define BLANK_STEP_CYC ((`BLANK_STEP_NS + `CLK_PERIOD_NS - 1) / `CLK_PERIOD_NS)
`define MIND_DENOM 512
`endif

// ==== pwm_sense_pkg.sv ====
// Types shared by the current-sense configuration block
package pwm_sense_pkg;
    // Sampling slope selection
    typedef enum logic [1:0] {
        meth_none_t_v = 2'b00,
        meth_down_t_v = 2'b01,
        meth_up_t_v = 2'b10,
        meth_rsvd_t_v = 2'b11
    } sense_method_t;
    // Measurement sequencer states
    typedef enum logic [1:0] {
        st_idle = 2'b00,
        st_blank = 2'b01,
        st_measure = 2'b10
    } meas_state_t;
endpackage
